// [hw/fdc_control.sv]
`timescale 1ns/1ps
`include "fdc_params.svh"
module fdc_control
(
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic             transfer_end_count,
    input  wire logic             dma_ack_n,
    input  wire logic             head_at_outer_track_n,
    input  wire logic             media_write_locked_n,
    input  wire logic             read_data_n,
    output logic                  write_data_o,
    output logic                  write_data_oe_n,
    output logic                  write_enable_gate_o,
    output logic                  write_enable_gate_oe_n,
    output logic                  low_rate_filter_switch,
    output logic                  high_rate_filter_switch,
    output fdc_pkg::core_clk_t    core_clk_sel,
    output logic                  core_tick,
    output logic [7:0]            drive_ctl
);
    import fdc_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [23:0] acc_inc(input longint hz);
        longint full;
        full = (hz * (64'sd1 <<< `ACC_W)) / `CLK_HZ;
        return full[23:0];
    endfunction : acc_inc

    function automatic core_clk_t core_for_rate(input logic [1:0] rate);
        case (rate)
            `RATE_1M:   return CORE_8M;
            `RATE_300K: return CORE_4M8;
            default:    return CORE_4M;
        endcase
    endfunction : core_for_rate

    // Half bit cells: one clock window, one data window per bit
    function automatic logic [23:0] cell_inc(input logic [1:0] rate);
        case (rate)
            `RATE_500K: return acc_inc(2 * `BIT_500K_HZ);
            `RATE_300K: return acc_inc(2 * `BIT_300K_HZ);
            `RATE_1M:   return acc_inc(2 * `BIT_1M_HZ);
            default:    return acc_inc(2 * `BIT_250K_HZ);
        endcase
    endfunction : cell_inc

    function automatic logic [23:0] core_inc(input core_clk_t sel);
        case (sel)
            CORE_8M:  return acc_inc(`CORE_8M_HZ);
            CORE_4M8: return acc_inc(`CORE_4M8_HZ);
            default:  return acc_inc(`CORE_4M_HZ);
        endcase
    endfunction : core_inc

    function automatic logic mapped(input logic [7:0] a);
        return a == `OFS_MAIN_STATUS || a == `OFS_DATA || a == `OFS_RATE
            || a == `OFS_DRIVE_CTL || a == `OFS_DRIVE_STAT;
    endfunction : mapped

    // ****************************************
    // State
    // ****************************************
    top_state_t r;
    top_state_t n;
    logic       ser_ready;
    logic       ser_busy;
    logic       ser_pulse;
    logic [7:0] des_data;
    logic       des_valid;
    logic       wr_exec;
    logic       rd_exec;
    logic       tc_qual;
    logic       locked;
    logic [7:0] msr;
    logic [24:0] core_sum;
    logic [24:0] cell_sum;
    logic       do_write;
    logic       do_read;

    assign wr_exec = r.phase == PH_WR_EXEC;
    assign rd_exec = r.phase == PH_RD_EXEC;
    assign tc_qual = r.tc_s[1] & ~r.dack_s[1];
    assign locked  = ~r.wp_s[1];

    // Handshake toward the host
    always_comb
    begin
        msr = 8'h00;
        case (r.phase)
            PH_IDLE:    msr[`MSR_RQM] = ~r.cmd_full;
            PH_WR_EXEC: msr[`MSR_RQM] = ~r.wbyte_full;
            PH_RD_EXEC: msr[`MSR_RQM] = r.rbyte_full;
            PH_RESULT:  msr[`MSR_RQM] = 1'b1;
            default:    msr[`MSR_RQM] = 1'b0;
        endcase
        msr[`MSR_DIO]  = rd_exec | (r.phase == PH_RESULT);
        msr[`MSR_EXEC] = wr_exec | rd_exec;
        msr[`MSR_BUSY] = r.phase != PH_IDLE || r.cmd_full;
    end

    assign s_axi_awready = ~r.aw_full;
    assign s_axi_wready  = ~r.w_full;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_arready = ~r.rvalid;
    assign s_axi_rvalid  = r.rvalid;
    assign s_axi_rdata   = r.rdata;
    assign s_axi_rresp   = r.rresp;
    assign do_write      = r.aw_full & r.w_full & ~r.bvalid;
    assign do_read       = s_axi_arvalid & ~r.rvalid;

    assign write_data_o           = 1'b0;
    assign write_data_oe_n        = ~r.wdat;
    assign write_enable_gate_o    = 1'b0;
    assign write_enable_gate_oe_n = ~r.gate;
    assign low_rate_filter_switch  = r.lo_sw;
    assign high_rate_filter_switch = r.hi_sw;
    assign core_clk_sel = r.core_sel;
    assign core_tick    = r.core_tick;
    assign drive_ctl    = r.drive_ctl;
    assign core_sum = {1'b0, r.core_acc} + {1'b0, core_inc(r.core_sel)};
    assign cell_sum = {1'b0, r.cell_acc} + {1'b0, cell_inc(r.rate)};

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        n = r;
        // Pins are asynchronous to this clock
        n.tc_s   = {r.tc_s[0], transfer_end_count};
        n.dack_s = {r.dack_s[0], dma_ack_n};
        n.trk_s  = {r.trk_s[0], head_at_outer_track_n};
        n.wp_s   = {r.wp_s[0], media_write_locked_n};
        n.rd_s   = {r.rd_s[0], read_data_n};

        // Switches follow the stored rate from flops, so no decode glitch
        n.core_sel  = core_for_rate(r.rate);
        n.hi_sw     = r.rate == `RATE_500K;
        n.lo_sw     = r.rate == `RATE_250K || r.rate == `RATE_300K;
        n.core_acc  = core_sum[23:0];
        n.core_tick = core_sum[24];
        n.cell_acc  = cell_sum[23:0];
        n.cell_tick = cell_sum[24];

        // AXI channels
        if (s_axi_awvalid && !r.aw_full)
        begin
            n.aw_full = 1'b1;
            n.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.w_full)
        begin
            n.w_full  = 1'b1;
            n.w_data  = s_axi_wdata[7:0];
            n.w_strb0 = s_axi_wstrb[0];
        end
        if (r.bvalid && s_axi_bready)
            n.bvalid = 1'b0;
        if (r.rvalid && s_axi_rready)
            n.rvalid = 1'b0;

        // Serializer takes the held byte
        if (ser_ready && r.wbyte_full && wr_exec)
            n.wbyte_full = 1'b0;

        // Register writes
        if (do_write)
        begin
            n.aw_full = 1'b0;
            n.w_full  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = mapped(r.aw_addr) ? 2'h0 : 2'h2;
            if (r.w_strb0)
            begin
                case (r.aw_addr)
                    `OFS_RATE:      n.rate = r.w_data[1:0];
                    `OFS_DRIVE_CTL: n.drive_ctl = r.w_data;
                    `OFS_DATA:
                    begin
                        // Bytes offered out of turn are dropped
                        if (r.phase == PH_IDLE && !r.cmd_full)
                        begin
                            n.cmd      = r.w_data;
                            n.cmd_full = 1'b1;
                        end
                        else if (wr_exec && !r.wbyte_full)
                        begin
                            n.wbyte      = r.w_data;
                            n.wbyte_full = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end

        // Deserialized byte; an unread one is lost and flagged
        if (des_valid && rd_exec)
        begin
            n.rbyte      = des_data;
            n.overrun    = r.overrun | r.rbyte_full;
            n.rbyte_full = 1'b1;
        end

        // Register reads
        if (do_read)
        begin
            n.rvalid = 1'b1;
            n.rresp  = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
            n.rdata  = 32'h0000_0000;
            case (s_axi_araddr)
                `OFS_MAIN_STATUS: n.rdata[7:0] = msr;
                `OFS_RATE:        n.rdata[1:0] = r.rate;
                `OFS_DRIVE_CTL:   n.rdata[7:0] = r.drive_ctl;
                `OFS_DRIVE_STAT:
                    n.rdata[3:0] = {r.gate, r.tc_seen, locked, ~r.trk_s[1]};
                `OFS_DATA:
                begin
                    if (rd_exec && r.rbyte_full)
                    begin
                        n.rdata[7:0] = r.rbyte;
                        if (!(des_valid && rd_exec))
                            n.rbyte_full = 1'b0;
                    end
                    else if (r.phase == PH_RESULT)
                    begin
                        n.rdata[7:0] = r.status;
                        n.phase      = PH_IDLE;
                    end
                end
                default: ;
            endcase
        end

        // Command sequencing, paced by the core clock
        if (r.core_tick)
        begin
            case (r.phase)
                PH_IDLE:
                begin
                    if (r.cmd_full)
                    begin
                        n.cmd_full = 1'b0;
                        n.overrun  = 1'b0;
                        n.tc_seen  = 1'b0;
                        if (r.cmd[3:0] == `CMD_WRITE && locked)
                        begin
                            n.status = `ST_ABNORMAL | `ST_NOT_WRITABLE;
                            n.phase  = PH_RESULT;
                        end
                        else if (r.cmd[3:0] == `CMD_WRITE)
                            n.phase = PH_WR_EXEC;
                        else if (r.cmd[3:0] == `CMD_READ)
                            n.phase = PH_RD_EXEC;
                        else
                        begin
                            n.status = `ST_INVALID;
                            n.phase  = PH_RESULT;
                        end
                    end
                end
                PH_WR_EXEC:
                begin
                    // Protection raised mid-write stops the write at once
                    if (locked)
                    begin
                        n.status     = `ST_ABNORMAL | `ST_NOT_WRITABLE;
                        n.wbyte_full = 1'b0;
                        n.phase      = PH_RESULT;
                    end
                    // A last pulse still in flight must leave inside the gate
                    else if (r.tc_seen && !r.wbyte_full && !ser_busy && !ser_pulse)
                    begin
                        n.status = `ST_NORMAL;
                        n.phase  = PH_RESULT;
                    end
                end
                PH_RD_EXEC:
                begin
                    if (r.tc_seen)
                    begin
                        n.status     = r.overrun ? `ST_ABNORMAL : `ST_NORMAL;
                        n.rbyte_full = 1'b0;
                        n.phase      = PH_RESULT;
                    end
                end
                PH_RESULT: ;
                default: n.phase = PH_IDLE;
            endcase
        end

        // Count seen after the clear above so a new one is never lost
        if (tc_qual && (wr_exec || rd_exec))
            n.tc_seen = 1'b1;
        n.gate = n.phase == PH_WR_EXEC && !locked;
        n.wdat = ser_pulse & n.gate;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            r           <= '0;
            r.phase     <= PH_IDLE;
            r.rate      <= `RATE_RESET;
            r.drive_ctl <= `DRIVE_CTL_RESET;
            r.core_sel  <= CORE_4M;
            r.lo_sw     <= 1'b1;
            r.tc_s      <= 2'h0;
            r.dack_s    <= 2'h3;
            r.trk_s     <= 2'h3;
            r.wp_s      <= 2'h3;
            r.rd_s      <= 2'h3;
        end
        else
            r <= n;
    end

    // ****************************************
    // Data path
    // ****************************************
    mfm_serializer u_ser
    (
        .clock      (clock),
        .nrst       (nrst),
        .enable     (wr_exec),
        .half_tick  (r.cell_tick),
        .byte_data  (r.wbyte),
        .byte_valid (r.wbyte_full & wr_exec),
        .byte_ready (ser_ready),
        .busy       (ser_busy),
        .pulse      (ser_pulse)
    );

    mfm_deserializer u_des
    (
        .clock      (clock),
        .nrst       (nrst),
        .enable     (rd_exec),
        .half_tick  (r.cell_tick),
        .rd_level   (~r.rd_s[1]),
        .byte_data  (des_data),
        .byte_valid (des_valid)
    );
endmodule : fdc_control

// [pkg/fdc_params.svh]
`ifndef FDC_PARAMS_SVH
`define FDC_PARAMS_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFS_MAIN_STATUS 8'h00
`define OFS_DATA        8'h04
`define OFS_RATE        8'h08
`define OFS_DRIVE_CTL   8'h0C
`define OFS_DRIVE_STAT  8'h10
// ****************************************
// Field codes and reset values
// ****************************************
`define RATE_500K       2'h0
`define RATE_300K       2'h1
`define RATE_250K       2'h2
`define RATE_1M         2'h3
`define RATE_RESET      `RATE_250K
`define DRIVE_CTL_RESET 8'h00
`define MSR_RQM         7
`define MSR_DIO         6
`define MSR_EXEC        5
`define MSR_BUSY        4
`define CMD_WRITE       4'h5
`define CMD_READ        4'h6
`define ST_NORMAL       8'h00
`define ST_ABNORMAL     8'h40
`define ST_INVALID      8'h80
`define ST_NOT_WRITABLE 8'h02
// ****************************************
// Timing
// ****************************************
`define CLK_HZ          125000000
`define CORE_4M_HZ      4000000
`define CORE_4M8_HZ     4800000
`define CORE_8M_HZ      8000000
`define BIT_250K_HZ     250000
`define BIT_300K_HZ     300000
`define BIT_500K_HZ     500000
`define BIT_1M_HZ       1000000
`define ACC_W           24
`endif

// [pkg/fdc_pkg.sv]
package fdc_pkg;
    typedef enum logic [1:0] {PH_IDLE, PH_WR_EXEC, PH_RD_EXEC, PH_RESULT} phase_t;
    typedef enum logic [1:0] {CORE_4M, CORE_4M8, CORE_8M} core_clk_t;
    typedef struct packed {
        logic [7:0] shreg;
        logic [2:0] count;
        logic       loaded;
        logic       window;
        logic       prev_bit;
        logic       pulse;
    } ser_state_t;
    typedef struct packed {
        logic       prev;
        logic       window;
        logic       seen;
        logic [7:0] shreg;
        logic [2:0] count;
        logic [7:0] data;
        logic       valid;
    } des_state_t;
    typedef struct packed {
        logic [1:0]  tc_s;
        logic [1:0]  dack_s;
        logic [1:0]  trk_s;
        logic [1:0]  wp_s;
        logic [1:0]  rd_s;
        phase_t      phase;
        logic [1:0]  rate;
        logic [7:0]  drive_ctl;
        core_clk_t   core_sel;
        logic        lo_sw;
        logic        hi_sw;
        logic [23:0] core_acc;
        logic [23:0] cell_acc;
        logic        core_tick;
        logic        cell_tick;
        logic [7:0]  cmd;
        logic        cmd_full;
        logic [7:0]  wbyte;
        logic        wbyte_full;
        logic [7:0]  rbyte;
        logic        rbyte_full;
        logic        overrun;
        logic [7:0]  status;
        logic        tc_seen;
        logic        gate;
        logic        wdat;
        logic        aw_full;
        logic [7:0]  aw_addr;
        logic        w_full;
        logic [7:0]  w_data;
        logic        w_strb0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } top_state_t;
endpackage : fdc_pkg

// [hw/mfm_serializer.sv]
`timescale 1ns/1ps
module mfm_serializer
(
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       enable,
    input  wire logic       half_tick,
    input  wire logic [7:0] byte_data,
    input  wire logic       byte_valid,
    output logic            byte_ready,
    output logic            busy,
    output logic            pulse
);
    import fdc_pkg::*;
    ser_state_t r;
    ser_state_t n;

    assign byte_ready = enable & ~r.loaded;
    assign busy       = r.loaded;
    assign pulse      = r.pulse;

    always_comb
    begin
        n       = r;
        n.pulse = 1'b0;
        if (byte_valid && byte_ready)
        begin
            n.shreg  = byte_data;
            n.count  = 3'h0;
            n.loaded = 1'b1;
            n.window = 1'b0;
        end
        else if (half_tick && r.loaded)
        begin
            n.window = ~r.window;
            if (!r.window)
                // Clock bit only between two zero data bits
                n.pulse = ~r.prev_bit & ~r.shreg[7];
            else
            begin
                n.pulse    = r.shreg[7];
                n.prev_bit = r.shreg[7];
                n.shreg    = {r.shreg[6:0], 1'b0};
                n.count    = r.count + 3'h1;
                if (r.count == 3'h7)
                    n.loaded = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            r <= '0;
        else
            r <= n;
    end
endmodule : mfm_serializer

// [hw/mfm_deserializer.sv]
`timescale 1ns/1ps
module mfm_deserializer
(
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       enable,
    input  wire logic       half_tick,
    input  wire logic       rd_level,
    output logic [7:0]      byte_data,
    output logic            byte_valid
);
    import fdc_pkg::*;
    des_state_t r;
    des_state_t n;
    logic       edge_seen;

    assign byte_data  = r.data;
    assign byte_valid = r.valid;

    always_comb
    begin
        n         = r;
        n.valid   = 1'b0;
        n.prev    = rd_level;
        edge_seen = rd_level & ~r.prev;
        if (edge_seen)
            n.seen = 1'b1;
        if (!enable)
        begin
            n.count  = 3'h0;
            n.window = 1'b0;
            n.seen   = 1'b0;
        end
        else if (half_tick)
        begin
            n.window = ~r.window;
            n.seen   = 1'b0;
            // Pulses in the clock window are dropped; only data windows shift in
            if (r.window)
            begin
                n.shreg = {r.shreg[6:0], r.seen | edge_seen};
                n.count = r.count + 3'h1;
                if (r.count == 3'h7)
                begin
                    n.data  = {r.shreg[6:0], r.seen | edge_seen};
                    n.valid = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            r <= '0;
        else
            r <= n;
    end
endmodule : mfm_deserializer

// [tb/fdc_control_chk.sv]
`timescale 1ns/1ps
module fdc_control_chk
import fdc_pkg::*;
(
    input wire logic      clock,
    input wire logic      nrst,
    input wire logic      s_axi_bvalid,
    input wire logic      s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic      s_axi_rvalid,
    input wire logic      s_axi_arready,
    input wire logic      media_write_locked_n,
    input wire logic      write_data_o,
    input wire logic      write_data_oe_n,
    input wire logic      write_enable_gate_oe_n,
    input wire logic      low_rate_filter_switch,
    input wire logic      high_rate_filter_switch,
    input wire core_clk_t core_clk_sel,
    input wire logic      core_tick
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    property p_sw; !(low_rate_filter_switch && high_rate_filter_switch); endproperty
    a_sw: assert property (p_sw) else $error("switch clash");
    property p_fast; core_clk_sel == CORE_8M |-> !low_rate_filter_switch
        && !high_rate_filter_switch; endproperty
    a_fast: assert property (p_fast) else $error("switch on at 1M");
    property p_mid; core_clk_sel == CORE_4M8 |-> low_rate_filter_switch; endproperty
    a_mid: assert property (p_mid) else $error("low switch off at 300k");
    property p_pulse; $fell(write_data_oe_n) |=> write_data_oe_n && !write_data_o; endproperty
    a_pulse: assert property (p_pulse) else $error("write pulse width");
    property p_gate; !write_data_oe_n |-> !write_enable_gate_oe_n; endproperty
    a_gate: assert property (p_gate) else $error("pulse outside gate");
    property p_lock; $fell(write_enable_gate_oe_n) |-> $past(media_write_locked_n, 3); endproperty
    a_lock: assert property (p_lock) else $error("gate while locked");
    property p_tick; core_tick |=> !core_tick; endproperty
    a_tick: assert property (p_tick) else $error("core tick too long");
    property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bh: assert property (p_bh) else $error("bvalid dropped");
    property p_ar; s_axi_arready == !s_axi_rvalid; endproperty
    a_ar: assert property (p_ar) else $error("arready with rvalid");
endmodule : fdc_control_chk
bind fdc_control fdc_control_chk i_fdc_control_chk (.*);

// [tb/drive_model.sv]
`timescale 1ns/1ps
module drive_model
(
    input  wire logic clock,
    input  wire logic write_data_o,
    input  wire logic write_data_oe_n,
    input  wire logic write_enable_gate_oe_n,
    input  wire logic lock,
    output logic      head_at_outer_track_n,
    output logic      media_write_locked_n,
    output logic      read_data_n,
    output int        pulses
);
    logic pin;
    logic pin_q = 1'b1;
    // Released open-drain pin floats high on the pull-up
    assign pin = write_data_oe_n ? 1'b1 : write_data_o;
    assign head_at_outer_track_n = 1'b0;
    assign media_write_locked_n = ~lock;
    assign read_data_n = 1'b1;
    initial pulses = 0;
    always @(posedge clock)
    begin
        pin_q <= pin;
        if (pin_q && !pin && !write_enable_gate_oe_n) pulses <= pulses + 1;
    end
endmodule : drive_model

// [tb/test_fdc_control.sv]
`timescale 1ns/1ps
`include "fdc_params.svh"
module test_fdc_control;
import fdc_pkg::*;
logic clock, nrst, lock, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
logic s_axi_rready, transfer_end_count, dma_ack_n, head_at_outer_track_n, core_tick;
logic media_write_locked_n, read_data_n, write_data_o, write_data_oe_n;
logic write_enable_gate_o, write_enable_gate_oe_n;
logic low_rate_filter_switch, high_rate_filter_switch;
logic [7:0] s_axi_awaddr, s_axi_araddr, drive_ctl, b;
logic [31:0] s_axi_wdata, s_axi_rdata;
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp, r;
core_clk_t core_clk_sel;
int pulses, errors, compares, i, k, n;
fdc_control i_fdc_control (.*);
drive_model i_drive_model (.*);
initial
begin
    clock = 0;
    forever #4 clock = ~clock;
end
task final_report;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
endtask : final_report
task chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1)
    begin
        errors++;
        $display("BAD %0t %s", $time, m);
    end
    if (n >= 3000) final_report;
endtask : chk
task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 3000 && !(!s_axi_awvalid && !s_axi_wvalid && s_axi_bvalid); n++)
    begin
        @(posedge clock);
        if (s_axi_awready) s_axi_awvalid <= 0;
        if (s_axi_wready) s_axi_wvalid <= 0;
    end
    r = s_axi_bresp;
    s_axi_bready <= 0;
    chk(n < 3000, "write timeout");
endtask : wr
task rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 3000 && !(!s_axi_arvalid && s_axi_rvalid); n++)
    begin
        @(posedge clock);
        if (s_axi_arready) s_axi_arvalid <= 0;
    end
    b = s_axi_rdata[7:0];
    s_axi_rready <= 0;
    chk(n < 3000 && s_axi_rdata[31:8] === 24'h0, "read");
endtask : rd
// Host polls the main status before every data access
task xfer(input logic [1:0] dir, input logic [7:0] d);
    for (k = 0; k < 3000; k++)
    begin
        rd(`OFS_MAIN_STATUS);
        if (b[7:6] === dir) break;
    end
    n = k;
    chk(k < 3000, "poll");
    if (dir[0]) rd(`OFS_DATA);
    else wr(`OFS_DATA, d);
endtask : xfer
task t_rates;
    logic lo[4] = '{0, 1, 1, 0};
    logic hi[4] = '{1, 0, 0, 0};
    int t[4] = '{40, 48, 40, 80};
    rd(`OFS_RATE);
    chk(b === 8'h02 && low_rate_filter_switch === 1 && core_clk_sel === CORE_4M, "reset");
    for (i = 0; i < 4; i++)
    begin
        wr(`OFS_RATE, i);
        repeat (2) @(posedge clock);
        chk(low_rate_filter_switch === lo[i] && high_rate_filter_switch === hi[i], "switch");
        k = 0;
        repeat (1250) @(posedge clock) k += (core_tick === 1'b1);
        chk(k >= t[i] - 1 && k <= t[i] + 1, "core rate");
    end
endtask : t_rates
task t_regs;
    chk(drive_ctl === 8'h00, "drive ctl reset");
    wr(`OFS_DRIVE_CTL, 8'hA5);
    rd(`OFS_DRIVE_CTL);
    chk(b === 8'hA5 && drive_ctl === 8'hA5, "drive ctl");
    wr(8'h20, 8'h00);
    chk(r === 2'h2, "unmapped");
    rd(`OFS_DRIVE_STAT);
    chk(b[0] === 1'b1, "outer track");
endtask : t_regs
task t_cmds;
    xfer(2'b10, 8'h0F);
    xfer(2'b11, 0);
    chk(b === `ST_INVALID, "bad command");
    lock <= 1;
    repeat (4) @(posedge clock);
    xfer(2'b10, `CMD_WRITE);
    xfer(2'b11, 0);
    chk(b === (`ST_ABNORMAL | `ST_NOT_WRITABLE), "locked write");
    lock <= 0;
    repeat (4) @(posedge clock);
endtask : t_cmds
task t_write;
    xfer(2'b10, `CMD_WRITE);
    xfer(2'b10, 8'hFF);
    transfer_end_count <= 1;
    repeat (20) @(posedge clock);
    rd(`OFS_DRIVE_STAT);
    chk(b[3:2] === 2'b10, "count without ack");
    dma_ack_n <= 0;
    repeat (10) @(posedge clock);
    transfer_end_count <= 0;
    dma_ack_n <= 1;
    xfer(2'b11, 0);
    chk(b === `ST_NORMAL && pulses == 8, "write end");
    chk(write_enable_gate_oe_n === 1'b1, "gate after write");
endtask : t_write
// Host resets just after issuing a read command and retries, as software does after a failing read
task t_retry;
    for (i = 0; i < 5; i++)
    begin
        xfer(2'b10, `CMD_READ);
        @(posedge clock);
        nrst <= 0;
        repeat (4) @(posedge clock);
        nrst <= 1;
        @(posedge clock);
        rd(`OFS_RATE);
        chk(b === 8'h02 && drive_ctl === 8'h00 && low_rate_filter_switch === 1'b1
            && high_rate_filter_switch === 1'b0 && write_data_oe_n === 1'b1
            && write_enable_gate_oe_n === 1'b1, "reset retry");
    end
endtask : t_retry
initial
begin
    {nrst, lock, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
    {s_axi_rready, transfer_end_count, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    {errors, compares, n} = 0;
    dma_ack_n = 1;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge clock);
    nrst <= 1;
    @(posedge clock);
    t_regs;
    t_rates;
    t_cmds;
    t_write;
    t_retry;
    final_report;
end
endmodule : test_fdc_control
